// ---- owd_option_word_decoder.sv ----
// option word decoder top: programmer port, store, reset-time capture
// Overview of operation
// - option words unreachable by running software
// - store holds two 13-bit words
// - bits 12 and 11 always one
// - bit 9 always zero
// - bit 10 zero enables error recovery
// - bit 8 selects two or four periods
// - bit 7 low enables watchdog
// - bit 6 one selects first variant
// - bit 5 selects crystal frequency range
// - range bit only matters for crystal
// - bit 4 selects RC or crystal
// - bit 3 selects oscillator drive power
// - protection on unless field all ones
// - word 1 is customer identification code
// - decode RC, high and low crystal modes
// - four periods gives timer clock divide four
module owd_option_word_decoder (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rstn,
	// programmer port
	input  wire logic                     prog_en,
	input  wire logic [1:0]               addr,
	input  wire logic [15:0]              wdata,
	input  wire logic                     wr,
	input  wire logic                     rd,
	output logic      [15:0]              rdata,
	// decoded controls
	output logic                          config_valid,
	output logic                          error_recovery_disable,
	output logic                          cycle_length_select,
	output logic                          watchdog_enable_n,
	output logic                          variant_first,
	output logic                          crystal_range_select,
	output logic                          oscillator_kind_select,
	output logic                          drive_power_select,
	output logic      [2:0]               protection_field,
	output logic                          code_protect_on,
	output logic                          external_rc_mode,
	output logic                          high_crystal_mode,
	output logic                          low_crystal_mode,
	output logic                          timer_counter_div4,
	output logic      [12:0]              customer_id
);
	import owd_pkg::*;

	owd_store_if  sif ();
	owd_decoded_s dec_live;
	logic         valid_q;
	logic         valid_d;
	owd_decoded_s dec_q;
	owd_decoded_s dec_d;
	owd_state_e   state_q;
	owd_state_e   state_d;
	logic [12:0]  id_q;
	logic [12:0]  id_d;
	logic [15:0]  rdata_q;
	logic [15:0]  rdata_d;
	logic [15:0]  status;

	// option word store
	owd_store u_store (
		.clk (clk),
		.sif (sif.store)
	);

	// live decode of the stored option word
	owd_decode u_decode_live (
		.word0 (sif.word0),
		.dec   (dec_live)
	);

	// programmer writes only reach the store while the programmer is attached
	always_comb begin
		sif.wr_en   = wr && prog_en && (addr == OWD_ADDR_WORD0 || addr == OWD_ADDR_WORD1);
		sif.wr_sel  = (addr == OWD_ADDR_WORD1);
		sif.wr_data = wdata[12:0];
	end

	// status view of the captured controls
	always_comb begin
		status                  = '0;
		status[OWD_ST_VALID]    = valid_q;
		status[OWD_ST_PROT]     = dec_q.code_protect_on;
		status[OWD_ST_ERC]      = dec_q.external_rc_mode;
		status[OWD_ST_HXT]      = dec_q.high_crystal_mode;
		status[OWD_ST_LXT]      = dec_q.low_crystal_mode;
		status[OWD_ST_DIV4]     = dec_q.timer_counter_div4;
	end

	// read data for the cycle after the strobe; nothing without the programmer
	always_comb begin
		rdata_d = '0;
		if (rd && prog_en) begin
			unique case (addr)
				OWD_ADDR_WORD0: begin
					rdata_d = {3'h0, sif.word0};
				end
				OWD_ADDR_WORD1: begin
					rdata_d = {3'h0, sif.word1};
				end
				OWD_ADDR_STATUS: begin
					rdata_d = status;
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	// read data register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= OWD_RDATA_RST;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// capture sequence: load once after reset release, then hold
	always_comb begin
		state_d = state_q;
		valid_d = valid_q;
		dec_d   = dec_q;
		id_d    = id_q;
		unique case (state_q)
			OWD_LOAD: begin
				dec_d   = dec_live;
				id_d    = sif.word1;
				valid_d = 1'b1;
				state_d = OWD_RUN;
			end
			OWD_RUN: begin
				state_d = OWD_RUN;
			end
		endcase
	end

	// captured controls; reset shows the reset word decode
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= OWD_LOAD;
			valid_q <= 1'b0;
			dec_q   <= OWD_DEC_RST;
			id_q    <= OWD_WORD1_RST;
		end else begin
			state_q <= state_d;
			valid_q <= valid_d;
			dec_q   <= dec_d;
			id_q    <= id_d;
		end
	end

	// outputs straight from the capture registers
	assign rdata                  = rdata_q;
	assign config_valid           = valid_q;
	assign error_recovery_disable = dec_q.error_recovery_disable;
	assign cycle_length_select    = dec_q.cycle_length_select;
	assign watchdog_enable_n      = dec_q.watchdog_enable_n;
	assign variant_first          = dec_q.variant_first;
	assign crystal_range_select   = dec_q.crystal_range_select;
	assign oscillator_kind_select = dec_q.oscillator_kind_select;
	assign drive_power_select     = dec_q.drive_power_select;
	assign protection_field       = dec_q.protection_field;
	assign code_protect_on        = dec_q.code_protect_on;
	assign external_rc_mode       = dec_q.external_rc_mode;
	assign high_crystal_mode      = dec_q.high_crystal_mode;
	assign low_crystal_mode       = dec_q.low_crystal_mode;
	assign timer_counter_div4     = dec_q.timer_counter_div4;
	assign customer_id            = id_q;
endmodule // owd_option_word_decoder

// ---- owd_pkg.sv ----
// constants and types shared by the option word decoder files
package owd_pkg;
	localparam int unsigned OWD_WORD_W   = 13;
	localparam int unsigned OWD_ADDR_W   = 2;
	localparam int unsigned OWD_DATA_W   = 16;
	// programmer port addresses
	localparam logic [1:0]  OWD_ADDR_WORD0  = 2'h0;
	localparam logic [1:0]  OWD_ADDR_WORD1  = 2'h1;
	localparam logic [1:0]  OWD_ADDR_STATUS = 2'h2;
	// option word 0 field positions
	localparam int unsigned OWD_BIT_RSV_HI  = 12;
	localparam int unsigned OWD_BIT_RSV_MID = 11;
	localparam int unsigned OWD_BIT_ERR_REC = 10;
	localparam int unsigned OWD_BIT_RSV_LO  = 9;
	localparam int unsigned OWD_BIT_CYCLE   = 8;
	localparam int unsigned OWD_BIT_WDOG_N  = 7;
	localparam int unsigned OWD_BIT_VARIANT = 6;
	localparam int unsigned OWD_BIT_RANGE   = 5;
	localparam int unsigned OWD_BIT_KIND    = 4;
	localparam int unsigned OWD_BIT_POWER   = 3;
	localparam int unsigned OWD_PROT_MSB    = 2;
	localparam int unsigned OWD_PROT_LSB    = 0;
	localparam logic [2:0]  OWD_PROT_OFF    = 3'h7;
	// reset values of the decoded outputs
	localparam logic [12:0] OWD_WORD0_RST   = 13'h1dff;
	localparam logic [12:0] OWD_WORD1_RST   = 13'h0000;
	localparam logic [15:0] OWD_RDATA_RST   = 16'h0000;
	// status register bit positions
	localparam int unsigned OWD_ST_VALID    = 0;
	localparam int unsigned OWD_ST_PROT     = 1;
	localparam int unsigned OWD_ST_ERC      = 2;
	localparam int unsigned OWD_ST_HXT      = 3;
	localparam int unsigned OWD_ST_LXT      = 4;
	localparam int unsigned OWD_ST_DIV4     = 5;

	typedef enum logic {
		OWD_LOAD,
		OWD_RUN
	} owd_state_e;

	typedef struct packed {
		logic       error_recovery_disable;
		logic       cycle_length_select;
		logic       watchdog_enable_n;
		logic       variant_first;
		logic       crystal_range_select;
		logic       oscillator_kind_select;
		logic       drive_power_select;
		logic [2:0] protection_field;
		logic       code_protect_on;
		logic       external_rc_mode;
		logic       high_crystal_mode;
		logic       low_crystal_mode;
		logic       timer_counter_div4;
	} owd_decoded_s;

	// decode of OWD_WORD0_RST, shown while reset is held
	localparam owd_decoded_s OWD_DEC_RST = owd_decoded_s'(15'h7fe5);

	// forces the reserved positions to their fixed values
	function automatic logic [12:0] owd_fix_reserved(input logic [12:0] w);
		logic [12:0] r;
		r = w;
		r[OWD_BIT_RSV_HI]  = 1'b1;
		r[OWD_BIT_RSV_MID] = 1'b1;
		r[OWD_BIT_RSV_LO]  = 1'b0;
		return r;
	endfunction
endpackage

// ---- owd_store_if.sv ----
// carrier between the decoder top and its option word store
interface owd_store_if;
	import owd_pkg::*;
	logic              wr_en;
	logic              wr_sel;
	logic [12:0]       wr_data;
	logic [12:0]       word0;
	logic [12:0]       word1;

	modport store (input wr_en, input wr_sel, input wr_data, output word0, output word1);
	modport user  (output wr_en, output wr_sel, output wr_data, input word0, input word1);
endinterface

// ---- owd_store.sv ----
// non-volatile option word store, two 13-bit words
module owd_store (
	// clock
	input  wire logic  clk,
	// store port
	owd_store_if.store sif
);
	import owd_pkg::*;

	logic [12:0] word0_q;
	logic [12:0] word0_d;
	logic [12:0] word1_q;
	logic [12:0] word1_d;

	// next contents; no reset, the words survive a device reset
	always_comb begin
		word0_d = word0_q;
		word1_d = word1_q;
		if (sif.wr_en && !sif.wr_sel) begin
			word0_d = owd_fix_reserved(sif.wr_data);
		end
		if (sif.wr_en && sif.wr_sel) begin
			word1_d = sif.wr_data;
		end
	end

	// word registers
	always_ff @(posedge clk) begin
		word0_q <= word0_d;
		word1_q <= word1_d;
	end

	assign sif.word0 = word0_q;
	assign sif.word1 = word1_q;
endmodule // owd_store

// ---- owd_decode.sv ----
// decodes option word 0 into control fields
module owd_decode (
	// option word
	input  wire logic [12:0]         word0,
	// decoded fields
	output owd_pkg::owd_decoded_s    dec
);
	import owd_pkg::*;

	logic kind;
	logic range;
	logic power;

	// field extraction and oscillator mode decode
	always_comb begin
		kind  = word0[OWD_BIT_KIND];
		range = word0[OWD_BIT_RANGE] & kind;
		power = word0[OWD_BIT_POWER];
		dec.error_recovery_disable = word0[OWD_BIT_ERR_REC];
		dec.cycle_length_select    = word0[OWD_BIT_CYCLE];
		dec.watchdog_enable_n      = word0[OWD_BIT_WDOG_N];
		dec.variant_first          = word0[OWD_BIT_VARIANT];
		dec.crystal_range_select   = range;
		dec.oscillator_kind_select = kind;
		dec.drive_power_select     = power;
		dec.protection_field       = word0[OWD_PROT_MSB:OWD_PROT_LSB];
		dec.code_protect_on        = (word0[OWD_PROT_MSB:OWD_PROT_LSB] != OWD_PROT_OFF);
		dec.external_rc_mode       = !kind;
		dec.high_crystal_mode      = kind & range;
		dec.low_crystal_mode       = kind & !range & !power;
		dec.timer_counter_div4     = word0[OWD_BIT_CYCLE];
	end
endmodule // owd_decode

// ---- owd_prog_model.sv ----
// programmer model driving the option word port
module owd_prog_model (
	// clock
	input  wire logic        clk,
	// programmer port
	output logic             prog_en,
	output logic [1:0]       addr,
	output logic [15:0]      wdata,
	output logic             wr,
	output logic             rd,
	input  wire logic [15:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		prog_en = 1'b1;
		addr = 2'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
	end
	// released lines show the inverse so stale values never pass
	task write(input logic [1:0] a, input logic [15:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~v;
	endtask
	// data taken at the edge ending the answer cycle
	task read(input logic [1:0] a, output logic [15:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		addr <= ~a;
		@(posedge clk);
		v = rdata;
	endtask
	task set_en(input logic v);
		@(posedge clk);
		prog_en <= v;
	endtask
endmodule // owd_prog_model

// ---- owd_option_word_decoder_sva.sv ----
// assertions on the option word decoder ports
module owd_chk (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        prog_en,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	input wire logic        config_valid,
	input wire logic        error_recovery_disable,
	input wire logic        cycle_length_select,
	input wire logic        crystal_range_select,
	input wire logic        oscillator_kind_select,
	input wire logic        drive_power_select,
	input wire logic [2:0]  protection_field,
	input wire logic        code_protect_on,
	input wire logic        external_rc_mode,
	input wire logic        high_crystal_mode,
	input wire logic        low_crystal_mode,
	input wire logic        timer_counter_div4,
	input wire logic [12:0] customer_id
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	rd_isolate_a: assert property (!$past(prog_en) || !$past(rd) |-> rdata == 16'h0)
		else $error("read data not zero");
	prot_decode_a: assert property (code_protect_on == (protection_field != 3'h7))
		else $error("protection decode wrong");
	rc_mode_a: assert property (external_rc_mode == !oscillator_kind_select)
		else $error("rc mode wrong");
	high_xtal_a: assert property (high_crystal_mode == (oscillator_kind_select
		&& crystal_range_select))
		else $error("high crystal mode wrong");
	low_xtal_a: assert property (low_crystal_mode == (oscillator_kind_select
		&& !crystal_range_select && !drive_power_select))
		else $error("low crystal mode wrong");
	range_gate_a: assert property (!oscillator_kind_select |-> !crystal_range_select)
		else $error("range set in rc mode");
	timer_div_a: assert property (timer_counter_div4 == cycle_length_select)
		else $error("timer divide wrong");
	valid_rise_a: assert property (!config_valid |=> config_valid)
		else $error("capture not done");
	hold_out_a: assert property (config_valid |=> $stable(customer_id)
		&& $stable(error_recovery_disable) && $stable(cycle_length_select))
		else $error("outputs moved while running");
	cover property (config_valid && high_crystal_mode);
	cover property (config_valid && low_crystal_mode);
	cover property (config_valid && external_rc_mode);
endmodule // owd_chk

bind owd_option_word_decoder owd_chk u_chk (.*);

// ---- owd_option_word_decoder_tb_top.sv ----
// self-checking bench for the option word decoder
module owd_option_word_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import owd_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic prog_en, wr, rd, config_valid, error_recovery_disable, cycle_length_select;
	logic watchdog_enable_n, variant_first, crystal_range_select, oscillator_kind_select;
	logic drive_power_select, code_protect_on, external_rc_mode, high_crystal_mode;
	logic low_crystal_mode, timer_counter_div4;
	logic [1:0]  addr;
	logic [2:0]  protection_field;
	logic [12:0] customer_id;
	logic [15:0] wdata, rdata, d, e;
	int n_fail = 0;
	int cmp_count = 0;

	initial forever #12.5 clk = ~clk;
	owd_option_word_decoder dut (.*);
	owd_prog_model prog (.*);

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task test_done;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task do_reset;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk("valid", {15'h0, config_valid}, 16'h0);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		chk("valid on", {15'h0, config_valid}, 16'h1);
	endtask
	// expected controls worked out from the option bits
	function automatic logic [15:0] exp_dec(input logic [12:0] w);
		return {1'b0, w[10], w[8], w[7], w[6], w[5] & w[4], w[4], w[3], w[2:0],
			w[2:0] != 3'h7, !w[4], w[4] & w[5], w[4] & !w[5] & !w[3], w[8]};
	endfunction
	task t_program(input logic [12:0] w0, input logic [12:0] w1, input logic [12:0] fx);
		prog.write(OWD_ADDR_WORD0, {3'h0, w0});
		prog.write(OWD_ADDR_WORD1, {3'h0, w1});
		prog.read(OWD_ADDR_WORD0, d);
		chk("word0", d, {3'h0, fx});
		prog.read(OWD_ADDR_WORD1, d);
		chk("word1", d, {3'h0, w1});
		prog.read(2'h3, d);
		chk("unmapped", d, 16'h0);
		do_reset;
		d = {1'b0, error_recovery_disable, cycle_length_select, watchdog_enable_n,
			variant_first, crystal_range_select, oscillator_kind_select, drive_power_select,
			protection_field, code_protect_on, external_rc_mode, high_crystal_mode,
			low_crystal_mode, timer_counter_div4};
		e = exp_dec(fx);
		chk("options", d & 16'h7800, e & 16'h7800);
		chk("oscillator", d & 16'h0700, e & 16'h0700);
		chk("protection", d & 16'h00f0, e & 16'h00f0);
		chk("modes", d & 16'h000f, e & 16'h000f);
		chk("customer_id", {3'h0, customer_id}, {3'h0, w1});
		// status view: valid, protect, rc, high, low, divide four
		e = {10'h0, fx[8], fx[4] & !fx[5] & !fx[3], fx[4] & fx[5], !fx[4],
			fx[2:0] != 3'h7, 1'b1};
		prog.read(OWD_ADDR_STATUS, d);
		chk("status", d, e);
		$display("program test done");
	endtask
	// port closed without the programmer, customer_id held over writes after capture
	task t_isolate;
		prog.set_en(1'b0);
		prog.write(OWD_ADDR_WORD1, 16'h0155);
		prog.read(OWD_ADDR_WORD1, d);
		chk("closed read", d, 16'h0);
		prog.set_en(1'b1);
		prog.read(OWD_ADDR_WORD1, d);
		chk("word1 kept", d, 16'h0aaa);
		prog.write(OWD_ADDR_WORD1, 16'h0123);
		repeat (2) @(posedge clk);
		chk("id held", {3'h0, customer_id}, 16'h0aaa);
		$display("isolation test done");
	endtask

	initial begin
		// the store has no reset: give it defined words before the first capture
		prog.write(OWD_ADDR_WORD0, 16'h1dff);
		prog.write(OWD_ADDR_WORD1, 16'h0000);
		do_reset;
		// rc words keep the range bit low, reserved bits set as required except in the first word, which the store fixes
		t_program(13'h0200, 13'h1fff, 13'h1800);
		t_program(13'h1dff, 13'h0001, 13'h1dff);
		t_program(13'h1d56, 13'h1000, 13'h1d56);
		t_program(13'h1837, 13'h0aaa, 13'h1837);
		t_isolate;
		test_done;
	end
endmodule // owd_option_word_decoder_tb_top
